// file: sss_pkg.sv
package sss_pkg;
	localparam logic [11:0] ADDR_STB   = 12'h000;
	localparam logic [11:0] ADDR_SRE   = 12'h004;
	localparam logic [11:0] ADDR_ESR   = 12'h008;
	localparam logic [11:0] ADDR_ESE   = 12'h00c;
	localparam logic [11:0] ADDR_OQ    = 12'h010;
	localparam logic [11:0] ADDR_POLL  = 12'h014;
	localparam logic [11:0] ADDR_CTRL  = 12'h018;
	localparam logic [11:0] ADDR_ISTAT = 12'h01c;
	localparam logic [11:0] ADDR_ICLR  = 12'h020;
	localparam logic [11:0] ADDR_IEN   = 12'h024;
	localparam int BIT_MAV = 4;
	localparam int BIT_ESB = 5;
	localparam int BIT_RQS = 6;
	localparam int BIT_PON = 7;
	localparam int CTRL_CLS = 0;
	localparam int ESR_QYE  = 2;
	localparam int IRQ_W   = 3;
	localparam int IRQ_SRQ = 0;
	localparam int IRQ_QYE = 1;
	localparam int IRQ_MAV = 2;
	localparam logic [7:0] ESR_RESET = 8'h80;
	localparam logic [7:0] SRE_MASK  = 8'hbf;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	typedef struct packed {
		logic       oq_valid;
		logic [7:0] oq_data;
	} sss_queue_s;
endpackage : sss_pkg

// file: sss_summary.sv
`timescale 1ns/10ps
`default_nettype none
module sss_summary (
	input  wire logic [7:0] events,
	input  wire logic [7:0] enables,
	output logic            summary
);
	assign summary = |(events & enables);
endmodule : sss_summary
`default_nettype wire

// file: sss_status.sv
`timescale 1ns/10ps
`default_nettype none
module sss_status (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [7:0]        std_event_set,
	input  wire logic [3:0]        dev_summary,
	input  wire sss_pkg::sss_queue_s oq_in,
	output logic                   oq_ready,
	output logic                   srq,
	output logic                   irq
);
	logic [7:0] esr_q;
	logic [7:0] ese_q;
	logic [7:0] sre_q;
	logic [7:0] oq_q;
	logic       oq_full_q;
	logic       rqs_q;
	logic       prev_req_q;
	logic [sss_pkg::IRQ_W-1:0] ist_q;
	logic [sss_pkg::IRQ_W-1:0] ien_q;
	logic       esb;
	logic [7:0] stb;
	logic       mss;
	logic       acc;
	logic       wr;
	logic       rd;
	logic       oq_rd;
	logic       qye_ev;
	logic [sss_pkg::IRQ_W-1:0] ev;
	logic       cls;
	logic       poll_rd;
	logic [7:0] wbyte;

	sss_summary u_esb (
		.events  (esr_q),
		.enables (ese_q),
		.summary (esb)
	);

	// Status byte is combinational from the sources
	always_comb begin
		stb = {4'h0, dev_summary};
		stb[sss_pkg::BIT_MAV] = oq_full_q;
		stb[sss_pkg::BIT_ESB] = esb;
		stb[sss_pkg::BIT_RQS] = 1'b0;
		stb[sss_pkg::BIT_PON] = 1'b0;
	end
	assign mss = |(stb & sre_q);

	assign acc   = psel & penable;
	assign oq_rd = acc & ~pwrite & (paddr == sss_pkg::ADDR_OQ);
	// Only an empty-queue read waits; other transfers finish at once
	assign pready = ~oq_rd | oq_full_q;
	assign wr    = acc & pwrite & pready;
	assign rd    = acc & ~pwrite & pready;
	assign pslverr = 1'b0;
	assign oq_ready = ~oq_full_q;
	assign srq = rqs_q;
	assign qye_ev = std_event_set[sss_pkg::ESR_QYE];
	// Clear-status empties event register and queue except for same-cycle events and arrivals, enables untouched
	assign cls     = wr & pwrite & (paddr == sss_pkg::ADDR_CTRL) & pwdata[sss_pkg::CTRL_CLS];
	assign poll_rd = rd & (paddr == sss_pkg::ADDR_POLL);
	// Low byte of a write, kept for the write checks
	assign wbyte   = pwdata[7:0];

	// Standard event register, power-on bit set at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			esr_q <= sss_pkg::ESR_RESET;
		end else begin
			if ((rd && paddr == sss_pkg::ADDR_ESR) || cls) begin
				esr_q <= std_event_set; // Set wins over read-clear
			end else begin
				esr_q <= esr_q | std_event_set;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ese_q <= sss_pkg::BYTE_ZERO;
			sre_q <= sss_pkg::BYTE_ZERO;
		end else begin
			if (wr && paddr == sss_pkg::ADDR_ESE) begin
				ese_q <= pwdata[7:0];
			end
			if (wr && paddr == sss_pkg::ADDR_SRE) begin
				sre_q <= pwdata[7:0] & sss_pkg::SRE_MASK;
			end
		end
	end

	// One-entry output queue; stalled readers finish when data lands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oq_q      <= sss_pkg::BYTE_ZERO;
			oq_full_q <= 1'b0;
		end else begin
			if (oq_rd && oq_full_q) begin
				oq_full_q <= 1'b0;
			end else if (oq_in.oq_valid && !oq_full_q) begin
				// Source already sees the byte taken, so it beats a clear
				oq_q      <= oq_in.oq_data;
				oq_full_q <= 1'b1;
			end else if (cls) begin
				oq_full_q <= 1'b0;
			end
		end
	end

	// Request-service: raised on a new enabled condition, dropped on poll
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rqs_q      <= 1'b0;
			prev_req_q <= 1'b0;
		end else begin
			prev_req_q <= mss;
			if (mss && !prev_req_q) begin
				rqs_q <= 1'b1;
			end else if (poll_rd || !mss) begin
				rqs_q <= 1'b0;
			end
		end
	end

	// Interrupt sources: new request, query error, byte accepted
	assign ev[sss_pkg::IRQ_SRQ] = mss & ~prev_req_q;
	assign ev[sss_pkg::IRQ_QYE] = qye_ev;
	assign ev[sss_pkg::IRQ_MAV] = oq_in.oq_valid & ~oq_full_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_q <= '0;
			ien_q <= '0;
		end else begin
			if (wr && paddr == sss_pkg::ADDR_ICLR) begin
				ist_q <= (ist_q & ~pwdata[sss_pkg::IRQ_W-1:0]) | ev;
			end else begin
				ist_q <= ist_q | ev;
			end
			if (wr && paddr == sss_pkg::ADDR_IEN) begin
				ien_q <= pwdata[sss_pkg::IRQ_W-1:0];
			end
		end
	end
	assign irq = |(ist_q & ien_q);

	always_comb begin
		prdata = sss_pkg::WORD_ZERO;
		if (rd) begin
			unique case (paddr)
				sss_pkg::ADDR_STB: begin
					prdata[7:0] = stb;
					prdata[sss_pkg::BIT_RQS] = mss;
				end
				sss_pkg::ADDR_POLL: begin
					prdata[7:0] = stb;
					prdata[sss_pkg::BIT_RQS] = rqs_q;
				end
				sss_pkg::ADDR_SRE:   prdata[7:0] = sre_q;
				sss_pkg::ADDR_ESR:   prdata[7:0] = esr_q;
				sss_pkg::ADDR_ESE:   prdata[7:0] = ese_q;
				sss_pkg::ADDR_OQ:    prdata[7:0] = oq_q;
				sss_pkg::ADDR_ISTAT: prdata[sss_pkg::IRQ_W-1:0] = ist_q;
				sss_pkg::ADDR_IEN:   prdata[sss_pkg::IRQ_W-1:0] = ien_q;
				default:             prdata = sss_pkg::WORD_ZERO;
			endcase
		end
	end

	property p_esb;
		@(posedge pclk) disable iff (!presetn) stb[sss_pkg::BIT_ESB] == |(esr_q & ese_q);
	endproperty
	a_esb: assert property (p_esb) else $error("ESB mismatch");

	property p_mav;
		@(posedge pclk) disable iff (!presetn) $rose(stb[sss_pkg::BIT_MAV]) |-> $past(ev[sss_pkg::IRQ_MAV]);
	endproperty
	a_mav: assert property (p_mav) else $error("MAV rose without a stored byte");

	property p_stall;
		@(posedge pclk) disable iff (!presetn) (oq_rd && !oq_full_q) |-> !pready;
	endproperty
	a_stall: assert property (p_stall) else $error("Empty queue read not stalled");

	property p_sre6;
		@(posedge pclk) disable iff (!presetn) sre_q[sss_pkg::BIT_RQS] == 1'b0;
	endproperty
	a_sre6: assert property (p_sre6) else $error("SRE bit 6 stored");

	property p_rise;
		@(posedge pclk) disable iff (!presetn) $rose(mss) |=> srq;
	endproperty
	a_rise: assert property (p_rise) else $error("Request not raised");

	property p_poll;
		@(posedge pclk) disable iff (!presetn) (rd && paddr == sss_pkg::ADDR_POLL && !$rose(mss)) |=> !srq;
	endproperty
	a_poll: assert property (p_poll) else $error("Poll did not clear request");

	property p_mss;
		@(posedge pclk) disable iff (!presetn) srq |-> $past(mss);
	endproperty
	a_mss: assert property (p_mss) else $error("Request without summary");

	property p_unused;
		@(posedge pclk) disable iff (!presetn) stb[sss_pkg::BIT_PON] == 1'b0 && stb[3:0] == dev_summary;
	endproperty
	a_unused: assert property (p_unused) else $error("Status byte layout wrong");

	property p_sticky;
		@(posedge pclk) disable iff (!presetn)
			(std_event_set != sss_pkg::BYTE_ZERO) |=> ((esr_q & $past(std_event_set)) == $past(std_event_set));
	endproperty
	a_sticky: assert property (p_sticky) else $error("Event lost");

	property p_mav_pop;
		@(posedge pclk) disable iff (!presetn) (oq_rd && pready) |=> !stb[sss_pkg::BIT_MAV];
	endproperty
	a_mav_pop: assert property (p_mav_pop) else $error("Queue not emptied by read");

	property p_esb_clr;
		@(posedge pclk) disable iff (!presetn)
			(rd && paddr == sss_pkg::ADDR_ESR && std_event_set == sss_pkg::BYTE_ZERO) |=> !stb[sss_pkg::BIT_ESB];
	endproperty
	a_esb_clr: assert property (p_esb_clr) else $error("ESB held after event read");

	property p_ist_srq;
		@(posedge pclk) disable iff (!presetn) ev[sss_pkg::IRQ_SRQ] |=> ist_q[sss_pkg::IRQ_SRQ];
	endproperty
	a_ist_srq: assert property (p_ist_srq) else $error("Request interrupt not recorded");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
			(ev[sss_pkg::IRQ_SRQ] && ien_q[sss_pkg::IRQ_SRQ] && !(wr && paddr == sss_pkg::ADDR_IEN)) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Enabled request gave no interrupt");

	property p_nowait;
		@(posedge pclk) disable iff (!presetn) (psel && penable && !oq_rd) |-> pready;
	endproperty
	a_nowait: assert property (p_nowait) else $error("Transfer stalled without queue read");

	property p_cls;
		@(posedge pclk) disable iff (!presetn) cls |=> esr_q == $past(std_event_set);
	endproperty
	a_cls: assert property (p_cls) else $error("Clear-status left stale events");

	property p_poll_data;
		@(posedge pclk) disable iff (!presetn) poll_rd |-> prdata[sss_pkg::BIT_RQS] == srq;
	endproperty
	a_poll_data: assert property (p_poll_data) else $error("Poll bit 6 not request-service");

	property p_rqs_drop;
		@(posedge pclk) disable iff (!presetn) !mss |=> !srq;
	endproperty
	a_rqs_drop: assert property (p_rqs_drop) else $error("Request held without summary");

	property p_sre_write;
		@(posedge pclk) disable iff (!presetn)
			(wr && paddr == sss_pkg::ADDR_SRE) |=> sre_q == ($past(wbyte) & sss_pkg::SRE_MASK);
	endproperty
	a_sre_write: assert property (p_sre_write) else $error("Request enable write wrong");

	property p_ese_write;
		@(posedge pclk) disable iff (!presetn) (wr && paddr == sss_pkg::ADDR_ESE) |=> ese_q == $past(wbyte);
	endproperty
	a_ese_write: assert property (p_ese_write) else $error("Event enable write wrong");

	property p_esb_set;
		@(posedge pclk) disable iff (!presetn)
			((std_event_set & ese_q) != sss_pkg::BYTE_ZERO && !(wr && paddr == sss_pkg::ADDR_ESE))
			|=> stb[sss_pkg::BIT_ESB];
	endproperty
	a_esb_set: assert property (p_esb_set) else $error("Enabled event gave no ESB");

	property p_queue_hold;
		@(posedge pclk) disable iff (!presetn) (stb[sss_pkg::BIT_MAV] && !oq_rd && !cls) |=> stb[sss_pkg::BIT_MAV];
	endproperty
	a_queue_hold: assert property (p_queue_hold) else $error("MAV dropped while byte held");

	property p_qye;
		@(posedge pclk) disable iff (!presetn) std_event_set[sss_pkg::ESR_QYE] |=> ist_q[sss_pkg::IRQ_QYE];
	endproperty
	a_qye: assert property (p_qye) else $error("Query error interrupt not recorded");

	c_srq:   cover property (@(posedge pclk) disable iff (!presetn) $rose(srq));
	c_stall: cover property (@(posedge pclk) disable iff (!presetn) oq_rd && !pready ##[1:20] pready);
	c_poll:  cover property (@(posedge pclk) disable iff (!presetn) srq ##1 (rd && paddr == sss_pkg::ADDR_POLL));
	c_cls:   cover property (@(posedge pclk) disable iff (!presetn) cls && oq_full_q);
	c_mav:   cover property (@(posedge pclk) disable iff (!presetn) $rose(stb[sss_pkg::BIT_MAV]));
endmodule : sss_status
`default_nettype wire

// file: sss_resp_src.sv
`timescale 1ns/10ps
`default_nettype none
module sss_resp_src (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          go,
	input  wire logic [7:0]    bval,
	input  wire logic [3:0]    dly,
	input  wire logic          oq_ready,
	output var sss_pkg::sss_queue_s oq_out
);
	logic       pend_q;
	logic [3:0] cnt_q;
	// Response generator: offers one byte after a delay, holds it until taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
			cnt_q  <= 4'h0;
			oq_out <= '0;
		end else begin
			if (go) begin
				pend_q <= 1'b1;
				cnt_q  <= dly;
			end else if (pend_q && cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end else if (pend_q && !oq_out.oq_valid) begin
				oq_out.oq_valid <= 1'b1;
				oq_out.oq_data  <= bval;
			end
			// Released data inverted so a late sample cannot look valid
			if (oq_out.oq_valid && oq_ready) begin
				oq_out.oq_valid <= 1'b0;
				oq_out.oq_data  <= ~oq_out.oq_data;
				pend_q          <= 1'b0;
			end
		end
	end
endmodule : sss_resp_src
`default_nettype wire

// file: status_summary_service_request_test.sv
`timescale 1ns/10ps
`default_nettype none
module status_summary_service_request_test;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, oq_ready, srq, irq, go;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, r;
	logic [7:0]          std_event_set, bval;
	logic [3:0]          dev_summary, dly;
	sss_pkg::sss_queue_s oq_in;
	int                  err_total, checks;
	sss_status i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.std_event_set(std_event_set), .dev_summary(dev_summary), .oq_in(oq_in),
		.oq_ready(oq_ready), .srq(srq), .irq(irq));
	sss_resp_src i_src (.pclk(pclk), .presetn(presetn), .go(go), .bval(bval), .dly(dly),
		.oq_ready(oq_ready), .oq_out(oq_in));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic results;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask : chk
	// Entered just after a rising edge; one idle cycle follows each transfer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, e, r);
	endtask : rd
	task automatic t_regs;
		rd(sss_pkg::ADDR_ESR, 32'h80, "esr power-on");
		rd(sss_pkg::ADDR_ESR, 32'h00, "esr after read");
		apb(1'b1, sss_pkg::ADDR_SRE, 32'hff);
		rd(sss_pkg::ADDR_SRE, 32'hbf, "sre");
		rd(12'h100, 32'h0, "unmapped");
		chk("pslverr", 32'h0, {31'h0, pslverr});
	endtask : t_regs
	task automatic t_event;
		apb(1'b1, sss_pkg::ADDR_ESE, 32'h04);
		apb(1'b1, sss_pkg::ADDR_IEN, 32'h7);
		std_event_set <= 8'h04;
		@(posedge pclk);
		std_event_set <= 8'h00;
		@(posedge pclk);
		rd(sss_pkg::ADDR_STB, 32'h60, "stb esb mss");
		chk("srq", 32'h1, {31'h0, srq});
		chk("irq", 32'h1, {31'h0, irq});
		rd(sss_pkg::ADDR_POLL, 32'h60, "poll rqs");
		chk("srq after poll", 32'h0, {31'h0, srq});
		rd(sss_pkg::ADDR_POLL, 32'h20, "poll cleared");
		apb(1'b1, sss_pkg::ADDR_ICLR, 32'h7);
		chk("irq clr", 32'h0, {31'h0, irq});
		rd(sss_pkg::ADDR_ESR, 32'h04, "esr qye");
		rd(sss_pkg::ADDR_STB, 32'h00, "stb esb off");
		dev_summary <= 4'ha;
		@(posedge pclk);
		rd(sss_pkg::ADDR_STB, 32'h4a, "stb dev");
		dev_summary <= 4'h0;
		apb(1'b1, sss_pkg::ADDR_ICLR, 32'h7);
	endtask : t_event
	task automatic t_queue;
		rd(sss_pkg::ADDR_STB, 32'h00, "mav empty");
		bval <= 8'h5a;
		dly  <= 4'h5;
		go   <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		rd(sss_pkg::ADDR_OQ, 32'h5a, "stalled read");
		bval <= 8'ha5;
		dly  <= 4'h2;
		go   <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		// Wait for message available before reading the queue
		repeat (20) begin
			apb(1'b0, sss_pkg::ADDR_STB, 32'h0);
			if (r[sss_pkg::BIT_MAV] === 1'b1) break;
		end
		chk("stb mav", 32'h50, r);
		rd(sss_pkg::ADDR_OQ, 32'ha5, "queue byte");
		rd(sss_pkg::ADDR_STB, 32'h00, "mav drained");
		rd(sss_pkg::ADDR_ISTAT, 32'h5, "irq status");
	endtask : t_queue
	// Clear-status with an event and a queued byte pending
	task automatic t_clear;
		std_event_set <= 8'h10;
		bval          <= 8'h3c;
		dly           <= 4'h0;
		go            <= 1'b1;
		@(posedge pclk);
		std_event_set <= 8'h00;
		go            <= 1'b0;
		repeat (3) @(posedge pclk);
		rd(sss_pkg::ADDR_STB, 32'h50, "mav before clear");
		apb(1'b1, sss_pkg::ADDR_CTRL, 32'h1);
		rd(sss_pkg::ADDR_ESR, 32'h00, "esr cleared");
		chk("srq after clear", 32'h0, {31'h0, srq});
		rd(sss_pkg::ADDR_STB, 32'h00, "mav cleared");
		rd(sss_pkg::ADDR_ESE, 32'h04, "ese kept");
		rd(sss_pkg::ADDR_IEN, 32'h7, "ien kept");
		apb(1'b1, sss_pkg::ADDR_ICLR, 32'h7);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask : t_clear
	initial begin
		repeat (3000) @(posedge pclk);
		err_total++;
		results();
	end
	initial begin
		{presetn, psel, penable, pwrite, go} = '0;
		{paddr, pwdata, std_event_set, bval, dev_summary, dly} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_event();
		t_queue();
		t_clear();
		results();
	end
endmodule : status_summary_service_request_test
`default_nettype wire
